// file: inc/tss_pkg.sv
package tswitch_pkg;
  localparam int ADDR_W = 32;
  localparam int SEL_W = 16;
  localparam int WORD_BYTES = 4;
  localparam int NREGS_DEF = 16;
  localparam int CPL_W = 2;
  localparam logic [CPL_W-1:0] CPL_PRIV = 2'h0;
  localparam logic SYS_FAULT_ADDR = 1'b0;
  localparam logic SYS_TASK_PTR = 1'b1;
  localparam logic [ADDR_W-1:0] FAULT_ADDR_RST = 32'h0000_0000;
  localparam logic [SEL_W-1:0] TP_SEL_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] TP_BASE_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] TP_LIMIT_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] REG_RST = 32'h0000_0000;
  // switch time budget: figure as printed, reference clock, our clock
  localparam int SWITCH_TIME_NS = 17000;
  localparam int REF_CLK_MHZ = 16;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] limit;
  } desc_s;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    desc_s desc;
  } task_ptr_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [CPL_W-1:0] cpl;
    logic sel;
    logic [ADDR_W-1:0] wdata;
  } sys_access_s;
endpackage

// file: logic/lin_addr_former.sv
`timescale 1ns/1ps
`default_nettype none
module lin_addr_former
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // segment base and offset
  input wire logic [tswitch_pkg::ADDR_W-1:0] seg_base,
  input wire logic [tswitch_pkg::ADDR_W-1:0] seg_off,
  // paging
  input wire logic paging_en,
  input wire logic [tswitch_pkg::ADDR_W-1:0] pg_phys,
  // addresses
  output logic [tswitch_pkg::ADDR_W-1:0] lin_q,
  output logic [tswitch_pkg::ADDR_W-1:0] phys_q
);
  import tswitch_pkg::*;

  logic [ADDR_W-1:0] lin_d;

  // wraps at 4 gigabytes, carry is dropped on purpose
  assign lin_d = seg_base + seg_off;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lin_q <= REG_RST;
      phys_q <= REG_RST;
    end
    else
    begin
      lin_q <= lin_d;
      // translator answers on the same clock from lin_q
      phys_q <= paging_en ? pg_phys : lin_d;
    end
  end

  property p_flat_phys;
    @(posedge sys_clk) disable iff (rst)
    !paging_en |=> (phys_q == lin_q) && (lin_q == $past(seg_base) + $past(seg_off));
  endproperty
  a_flat_phys: assert property (p_flat_phys) else $error("flat address mismatch");
endmodule // lin_addr_former
`default_nettype wire

// file: logic/sys_reg_gate.sv
`timescale 1ns/1ps
`default_nettype none
module sys_reg_gate
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // page fault report
  input wire logic page_fault,
  input wire logic [tswitch_pkg::ADDR_W-1:0] fault_lin,
  // system register access
  input wire tswitch_pkg::sys_access_s acc,
  input wire tswitch_pkg::task_ptr_s task_ptr,
  output logic ack_q,
  output logic priv_fault_q,
  output logic [tswitch_pkg::ADDR_W-1:0] rdata_q,
  output logic [tswitch_pkg::ADDR_W-1:0] fault_address_reg_q
);
  import tswitch_pkg::*;

  logic allowed;

  assign allowed = acc.req && (acc.cpl == CPL_PRIV);

  // a fault in the same cycle as a write wins: the handler needs it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      fault_address_reg_q <= FAULT_ADDR_RST;
    else if (page_fault)
      fault_address_reg_q <= fault_lin;
    else if (allowed && acc.we && acc.sel == SYS_FAULT_ADDR)
      fault_address_reg_q <= acc.wdata;
  end

  // task pointer is read-only here, only a switch reloads it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      priv_fault_q <= 1'b0;
      rdata_q <= REG_RST;
    end
    else
    begin
      ack_q <= allowed;
      priv_fault_q <= acc.req && !allowed;
      if (allowed && !acc.we)
        rdata_q <= (acc.sel == SYS_TASK_PTR) ? ADDR_W'(task_ptr.sel) : fault_address_reg_q;
      else
        rdata_q <= REG_RST;
    end
  end

  property p_fault_capture;
    @(posedge sys_clk) disable iff (rst)
    page_fault |=> fault_address_reg_q == $past(fault_lin);
  endproperty
  a_fault_capture: assert property (p_fault_capture) else $error("fault address lost");

  property p_user_denied;
    @(posedge sys_clk) disable iff (rst)
    acc.req && acc.cpl != CPL_PRIV && !page_fault
      |=> priv_fault_q && !ack_q && $stable(fault_address_reg_q);
  endproperty
  a_user_denied: assert property (p_user_denied) else $error("user access not denied");
endmodule // sys_reg_gate
`default_nettype wire

// file: logic/task_switch_sequencer.sv
// Notes on behaviour
// - a page fault stores its linear address in fault_address_reg for the handler.
// - system registers are read or written only at privileged level, else denied.
// - task_pointer_reg holds selector and cached descriptor of the running task.
// - a task jump first saves the registers into the outgoing task_state_block.
// - after the save, task_pointer_reg takes the jump's selector and descriptor.
// - registers are restored from the new block's base, then fetch resumes at its ip.
// - the saved ip points past the jump, so the task resumes after it.
// - only the architectural lower part of a task_state_block is touched.
// - a whole switch should finish within about 17 us (16 MHz reference).
// - each memory reference is segment base plus offset, optionally paged.
// - linear address is base plus offset, passed unchanged when paging is off.
`timescale 1ns/1ps
`default_nettype none
module task_switch_sequencer
#(
  parameter int NREGS = tswitch_pkg::NREGS_DEF
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // task jump request
  input wire logic jump_req,
  input wire logic [tswitch_pkg::SEL_W-1:0] jump_sel,
  input wire tswitch_pkg::desc_s jump_desc,
  input wire logic [tswitch_pkg::ADDR_W-1:0] jump_next_ip,
  // core register writes
  input wire logic reg_wr,
  input wire logic [$clog2(NREGS)-1:0] reg_idx,
  input wire logic [tswitch_pkg::ADDR_W-1:0] reg_wdata,
  // memory port
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [tswitch_pkg::ADDR_W-1:0] mem_addr_q,
  output logic [tswitch_pkg::ADDR_W-1:0] mem_lin_q,
  output logic [tswitch_pkg::ADDR_W-1:0] mem_wdata_q,
  input wire logic mem_ack,
  input wire logic [tswitch_pkg::ADDR_W-1:0] mem_rdata,
  // paging
  input wire logic paging_en,
  input wire logic [tswitch_pkg::ADDR_W-1:0] pg_phys,
  // page fault
  input wire logic page_fault,
  input wire logic [tswitch_pkg::ADDR_W-1:0] fault_lin,
  // system register access
  input wire tswitch_pkg::sys_access_s sys_acc,
  output logic sys_ack_q,
  output logic priv_fault_q,
  output logic [tswitch_pkg::ADDR_W-1:0] sys_rdata_q,
  output logic [tswitch_pkg::ADDR_W-1:0] fault_address_reg_q,
  // interrupts
  input wire logic irq_req,
  output logic irq_take_q,
  // status and fetch
  output var tswitch_pkg::task_ptr_s task_pointer_reg_q,
  output logic busy_q,
  output logic fetch_req_q,
  output logic [tswitch_pkg::ADDR_W-1:0] fetch_ip_q,
  output logic overrun_q
);
  import tswitch_pkg::*;

  localparam int WI = $clog2(NREGS);
  localparam logic [WI-1:0] LAST_WORD = WI'(NREGS - 1);
  localparam logic [CNT_W-1:0] BUDGET = CNT_W'(SWITCH_CYCLES);
  localparam logic [ADDR_W-1:0] ARCH_BYTES = ADDR_W'(NREGS * WORD_BYTES);

  typedef enum logic [2:0] {IDLE, ADR, SET, XFER, RELOAD, RESUME} seq_e;

  seq_e state_q;
  logic restoring_q;
  logic [WI-1:0] word_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] off_q;
  logic [ADDR_W-1:0] next_ip_q;
  logic [SEL_W-1:0] pend_sel_q;
  desc_s pend_desc_q;
  logic [ADDR_W-1:0] regs_q [NREGS];
  logic [CNT_W-1:0] cyc_q;
  logic last_word;
  logic start;

  assign last_word = (word_q == LAST_WORD);
  assign start = (state_q == IDLE) && jump_req;

  lin_addr_former i_lin_addr_former
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .seg_base(base_q),
    .seg_off(off_q),
    .paging_en(paging_en),
    .pg_phys(pg_phys),
    .lin_q(mem_lin_q),
    .phys_q(mem_addr_q)
  );

  sys_reg_gate i_sys_reg_gate
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .page_fault(page_fault),
    .fault_lin(fault_lin),
    .acc(sys_acc),
    .task_ptr(task_pointer_reg_q),
    .ack_q(sys_ack_q),
    .priv_fault_q(priv_fault_q),
    .rdata_q(sys_rdata_q),
    .fault_address_reg_q(fault_address_reg_q)
  );

  // sequencer: one word per pass through adr, set, xfer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      restoring_q <= 1'b0;
      word_q <= '0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if (jump_req)
          begin
            state_q <= ADR;
            restoring_q <= 1'b0;
            word_q <= '0;
          end
        end
        ADR: state_q <= SET;
        SET: state_q <= XFER;
        XFER:
        begin
          if (mem_ack)
          begin
            if (!last_word)
            begin
              word_q <= word_q + 1'b1;
              state_q <= ADR;
            end
            else if (!restoring_q)
              state_q <= RELOAD;
            else
              state_q <= RESUME;
          end
        end
        RELOAD:
        begin
          restoring_q <= 1'b1;
          word_q <= '0;
          state_q <= ADR;
        end
        RESUME: state_q <= IDLE;
      endcase
    end
  end

  // pending target latched at start so the jump operands may change
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_sel_q <= TP_SEL_RST;
      pend_desc_q <= '{base: TP_BASE_RST, limit: TP_LIMIT_RST};
      next_ip_q <= REG_RST;
    end
    else if (start)
    begin
      pend_sel_q <= jump_sel;
      pend_desc_q <= jump_desc;
      next_ip_q <= jump_next_ip;
    end
  end

  // segment base and offset for the address former
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      base_q <= TP_BASE_RST;
      off_q <= REG_RST;
    end
    else
    begin
      if (start)
        base_q <= task_pointer_reg_q.desc.base;
      else if (state_q == RELOAD)
        base_q <= pend_desc_q.base;
      // offsets stay below the architectural size, upper part untouched
      if (state_q == ADR)
        off_q <= ADDR_W'({word_q, 2'b00});
    end
  end

  // memory request held until acknowledged
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= REG_RST;
    end
    else if (state_q == SET)
    begin
      mem_req_q <= 1'b1;
      mem_we_q <= !restoring_q;
      // slot zero is the ip; the saved one already points past the jump
      mem_wdata_q <= (word_q == '0) ? next_ip_q : regs_q[word_q];
    end
    else if (state_q == XFER && mem_ack)
    begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
    end
  end

  // register file: restore beats core writes; core is stalled while busy
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NREGS; i++)
        regs_q[i] <= REG_RST;
    end
    else if (state_q == XFER && mem_ack && restoring_q)
      regs_q[word_q] <= mem_rdata;
    else if (reg_wr && state_q == IDLE)
      regs_q[reg_idx] <= reg_wdata;
  end

  // task pointer changes only after the whole save
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      task_pointer_reg_q <= '{sel: TP_SEL_RST, desc: '{base: TP_BASE_RST, limit: TP_LIMIT_RST}};
    else if (state_q == RELOAD)
      task_pointer_reg_q <= '{sel: pend_sel_q, desc: pend_desc_q};
  end

  // busy, fetch and interrupt acceptance
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      fetch_req_q <= 1'b0;
      fetch_ip_q <= REG_RST;
      irq_take_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_q == IDLE) ? jump_req : (state_q != RESUME);
      fetch_req_q <= (state_q == RESUME);
      if (state_q == RESUME)
        fetch_ip_q <= regs_q[0];
      // a jump in the same cycle has priority over the interrupt
      irq_take_q <= irq_req && state_q == IDLE && !jump_req;
    end
  end

  // budget check: a slow memory makes the switch miss its target
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cyc_q <= '0;
      overrun_q <= 1'b0;
    end
    else if (start)
    begin
      cyc_q <= '0;
      overrun_q <= 1'b0;
    end
    else if (state_q != IDLE)
    begin
      if (cyc_q != '1)
        cyc_q <= cyc_q + 1'b1;
      if (cyc_q >= BUDGET)
        overrun_q <= 1'b1;
    end
  end

  property p_ptr_hold;
    @(posedge sys_clk) disable iff (rst)
    state_q != RELOAD |=> $stable(task_pointer_reg_q);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("task pointer moved outside reload");

  property p_save_first;
    @(posedge sys_clk) disable iff (rst)
    mem_req_q && mem_we_q |-> !restoring_q && task_pointer_reg_q.desc.base == base_q;
  endproperty
  a_save_first: assert property (p_save_first) else $error("save not to outgoing block");

  property p_ptr_load;
    @(posedge sys_clk) disable iff (rst)
    state_q == RELOAD |=> task_pointer_reg_q.sel == $past(pend_sel_q)
      && task_pointer_reg_q.desc == $past(pend_desc_q) && state_q == ADR;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("task pointer not loaded");

  property p_resume_fetch;
    @(posedge sys_clk) disable iff (rst)
    state_q == RESUME |=> fetch_req_q && fetch_ip_q == $past(regs_q[0]) ##1 !fetch_req_q;
  endproperty
  a_resume_fetch: assert property (p_resume_fetch) else $error("fetch not at restored ip");

  property p_restore_base;
    @(posedge sys_clk) disable iff (rst)
    mem_req_q && !mem_we_q |-> base_q == task_pointer_reg_q.desc.base && restoring_q;
  endproperty
  a_restore_base: assert property (p_restore_base) else $error("restore off new base");

  property p_saved_ip;
    @(posedge sys_clk) disable iff (rst)
    mem_req_q && mem_we_q && word_q == '0 |-> mem_wdata_q == next_ip_q;
  endproperty
  a_saved_ip: assert property (p_saved_ip) else $error("saved ip not past jump");

  property p_lower_part;
    @(posedge sys_clk) disable iff (rst)
    mem_req_q |-> off_q < ARCH_BYTES && mem_lin_q == base_q + off_q;
  endproperty
  a_lower_part: assert property (p_lower_part) else $error("access beyond lower part");

  property p_budget;
    @(posedge sys_clk) disable iff (rst)
    state_q != IDLE && !start && cyc_q > BUDGET |-> overrun_q;
  endproperty
  a_budget: assert property (p_budget) else $error("overrun not flagged");

  property p_no_irq;
    @(posedge sys_clk) disable iff (rst)
    busy_q |-> !irq_take_q;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt taken during switch");
endmodule // task_switch_sequencer
`default_nettype wire

// file: test/task_switch_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module task_switch_sequencer_tb;
  import tswitch_pkg::*;
  localparam int NR = 4;
  localparam logic [31:0] SENT = 32'h5e47_1e10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic jump_req, reg_wr, mem_ack, paging_en, page_fault, irq_req;
  logic [SEL_W-1:0] jump_sel;
  desc_s jump_desc;
  logic [ADDR_W-1:0] jump_next_ip, reg_wdata, mem_rdata, pg_phys, fault_lin;
  logic [1:0] reg_idx;
  sys_access_s sys_acc;
  logic mem_req_q, mem_we_q, sys_ack_q, priv_fault_q, irq_take_q, busy_q, fetch_req_q, overrun_q;
  logic [ADDR_W-1:0] mem_addr_q, mem_lin_q, mem_wdata_q, sys_rdata_q;
  logic [ADDR_W-1:0] fault_address_reg_q, fetch_ip_q;
  task_ptr_s task_pointer_reg_q;
  int num_errors = 0;
  int total_checks = 0;
  int bad_irq = 0;
  int stall_left = 0;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] la[$];
  logic lw[$];
  logic [15:0] ls[$];

  always #2.5 sys_clk = ~sys_clk;

  task_switch_sequencer #(.NREGS(NR)) i_task_switch_sequencer (
    .sys_clk(sys_clk), .rst(rst),
    .jump_req(jump_req), .jump_sel(jump_sel), .jump_desc(jump_desc),
    .jump_next_ip(jump_next_ip),
    .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
    .mem_lin_q(mem_lin_q), .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .paging_en(paging_en), .pg_phys(pg_phys),
    .page_fault(page_fault), .fault_lin(fault_lin), .sys_acc(sys_acc),
    .sys_ack_q(sys_ack_q), .priv_fault_q(priv_fault_q), .sys_rdata_q(sys_rdata_q),
    .fault_address_reg_q(fault_address_reg_q), .irq_req(irq_req),
    .irq_take_q(irq_take_q), .task_pointer_reg_q(task_pointer_reg_q),
    .busy_q(busy_q), .fetch_req_q(fetch_req_q), .fetch_ip_q(fetch_ip_q),
    .overrun_q(overrun_q)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // memory: ack one cycle late, or after stall_left waits; read data scrambled when not answering
  always @(posedge sys_clk)
  begin
    if (mem_req_q && mem_ack)
    begin
      la.push_back(mem_addr_q);
      lw.push_back(mem_we_q);
      ls.push_back(task_pointer_reg_q.sel);
      check(mem_addr_q, mem_lin_q, "physical differs from linear");
      if (mem_we_q)
        mem[mem_addr_q] = mem_wdata_q;
    end
    if (irq_take_q && busy_q)
      bad_irq++;
    mem_ack <= mem_req_q && !mem_ack && stall_left == 0;
    mem_rdata <= (mem_req_q && !mem_ack && stall_left == 0 && mem.exists(mem_addr_q))
                 ? mem[mem_addr_q] : ~mem_rdata;
    if (mem_req_q && !mem_ack && stall_left > 0)
      stall_left--;
  end

  task automatic sys_op(input logic we, input logic [1:0] cpl, input logic s,
                        input logic [31:0] wd, input logic [31:0] exp_rd, input logic ok);
    @(posedge sys_clk);
    sys_acc <= '{req: 1'b1, we: we, cpl: cpl, sel: s, wdata: wd};
    @(posedge sys_clk);
    sys_acc.req <= 1'b0;
    #1;
    check(sys_ack_q, ok, "system ack");
    check(priv_fault_q, !ok, "privilege fault");
    if (!we)
      check(sys_rdata_q, exp_rd, "system read data");
  endtask

  task automatic t_irq();
    @(posedge sys_clk);
    irq_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(irq_take_q, 1'b1, "idle interrupt");
  endtask

  task automatic t_fault_and_priv();
    @(posedge sys_clk);
    page_fault <= 1'b1;
    fault_lin <= 32'h0bad_f00c;
    @(posedge sys_clk);
    page_fault <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(fault_address_reg_q, 32'h0bad_f00c, "fault address");
    sys_op(1'b0, 2'h0, 1'b0, 32'h0, 32'h0bad_f00c, 1'b1);
    // every unprivileged level must be refused, reads return zero
    for (int c = 1; c < 4; c++)
    begin
      sys_op(1'b1, c[1:0], 1'b0, 32'hdead_0000, 32'h0, 1'b0);
      sys_op(1'b0, c[1:0], 1'b0, 32'h0, 32'h0, 1'b0);
    end
    check(fault_address_reg_q, 32'h0bad_f00c, "denied write landed");
    sys_op(1'b1, 2'h0, 1'b0, 32'h1234_5678, 32'h0, 1'b1);
    check(fault_address_reg_q, 32'h1234_5678, "privileged write");
    // fault and privileged write in one cycle: the fault address must win
    @(posedge sys_clk);
    page_fault <= 1'b1;
    fault_lin <= 32'h0000_5a5c;
    sys_acc <= '{req: 1'b1, we: 1'b1, cpl: 2'h0, sel: 1'b0, wdata: 32'h0000_7777};
    @(posedge sys_clk);
    page_fault <= 1'b0;
    sys_acc.req <= 1'b0;
    #1;
    check(sys_ack_q, 1'b1, "write beside fault");
    check(fault_address_reg_q, 32'h0000_5a5c, "fault lost to write");
  endtask

  task automatic do_switch(input logic [15:0] sel, input logic [31:0] obase,
                           input logic [31:0] nbase, input logic [31:0] nip,
                           input logic [15:0] osel);
    int cyc;
    logic [31:0] exp_ip;
    exp_ip = mem[nbase];
    la.delete();
    lw.delete();
    ls.delete();
    @(posedge sys_clk);
    jump_req <= 1'b1;
    jump_sel <= sel;
    jump_desc <= '{base: nbase, limit: 32'h0000_00ff};
    jump_next_ip <= nip;
    @(posedge sys_clk);
    jump_req <= 1'b0;
    #1;
    check(busy_q, 1'b1, "busy after jump");
    check(irq_take_q, 1'b0, "interrupt beat the jump");
    // a second jump mid-switch must be ignored
    for (cyc = 0; cyc < 200; cyc++)
    begin
      @(posedge sys_clk);
      jump_req <= (cyc == 5);
      jump_sel <= 16'h00ff;
      #1;
      if (fetch_req_q)
        break;
    end
    if (cyc >= 200)
    begin
      num_errors++;
      final_report();
    end
    else
    begin
      check(fetch_ip_q, exp_ip, "resume ip");
      check(cyc <= 8 * NR + 4, 1'b1, "switch too long");
      check(overrun_q, 1'b0, "overrun flagged");
      check(task_pointer_reg_q.sel, sel, "task pointer selector");
      check(task_pointer_reg_q.desc.base, nbase, "task pointer base");
      check(la.size(), 2 * NR, "transfer count");
      for (int i = 0; i < 2 * NR; i++)
      begin
        check(la[i], (i < NR ? obase : nbase) + 4 * (i % NR), "transfer address");
        check(lw[i], i < NR, "transfer direction");
        check(ls[i], i < NR ? osel : sel, "task pointer at transfer");
      end
      check(mem[obase], nip, "saved ip");
      check(bad_irq, 0, "interrupt taken mid switch");
    end
  endtask

  task automatic t_switches();
    for (int i = 0; i < NR; i++)
    begin
      mem[32'h1000 + 4 * i] = 32'h0a00_0000 + i;
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_idx <= i[1:0];
      reg_wdata <= 32'hc0de_0000 + i;
    end
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    mem[32'h1000 + 4 * NR] = SENT;
    do_switch(16'h0028, 32'h0, 32'h1000, 32'h0000_0404, 16'h0000);
    for (int i = 1; i < NR; i++)
      check(mem[4 * i], 32'hc0de_0000 + i, "saved register");
    check(mem[32'h1000 + 4 * NR], SENT, "upper part touched");
    sys_op(1'b0, 2'h0, 1'b1, 32'h0, 32'h0000_0028, 1'b1);
    // switching back resumes the first task after its jump
    do_switch(16'h0030, 32'h1000, 32'h0, 32'h0000_0808, 16'h0028);
    for (int i = 1; i < NR; i++)
      check(mem[32'h1000 + 4 * i], 32'h0a00_0000 + i, "restored register");
  endtask

  // translated address must replace the linear one on the memory port
  task automatic t_paging();
    @(posedge sys_clk);
    paging_en <= 1'b1;
    pg_phys <= 32'h00ab_c000;
    repeat (2) @(posedge sys_clk);
    #1;
    check(mem_addr_q, 32'h00ab_c000, "paged physical");
    @(posedge sys_clk);
    paging_en <= 1'b0;
  endtask

  // a stalled memory pushes the switch past its budget
  task automatic t_overrun();
    int cyc;
    stall_left = 3500;
    @(posedge sys_clk);
    jump_req <= 1'b1;
    jump_sel <= 16'h0038;
    jump_desc <= '{base: 32'h1000, limit: 32'h0000_00ff};
    jump_next_ip <= 32'h0000_0c0c;
    @(posedge sys_clk);
    jump_req <= 1'b0;
    for (cyc = 0; cyc < 4000; cyc++)
    begin
      @(posedge sys_clk);
      #1;
      if (fetch_req_q)
        break;
    end
    if (cyc >= 4000)
    begin
      num_errors++;
      final_report();
    end
    else
    begin
      check(overrun_q, 1'b1, "slow switch not flagged");
      // the next jump clears the flag and returns to the earlier task
      do_switch(16'h0040, 32'h1000, 32'h0, 32'h0000_0d0d, 16'h0038);
    end
  endtask

  initial
  begin
    jump_req = 1'b0;
    jump_sel = '0;
    jump_desc = '0;
    jump_next_ip = '0;
    reg_wr = 1'b0;
    reg_idx = '0;
    reg_wdata = '0;
    mem_ack = 1'b0;
    mem_rdata = '0;
    // paging translation lives outside; left off so linear must equal physical
    paging_en = 1'b0;
    pg_phys = '0;
    page_fault = 1'b0;
    fault_lin = '0;
    sys_acc = '0;
    irq_req = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check(task_pointer_reg_q.sel, 16'h0000, "reset selector");
    check(fault_address_reg_q, 32'h0, "reset fault address");
    t_irq();
    t_fault_and_priv();
    t_paging();
    t_switches();
    t_overrun();
    final_report();
  end
endmodule // task_switch_sequencer_tb
`default_nettype wire
